// *** core/sfrb_cfg.svh ***
// Constants of the banked register block: register indices, reset values and field masks.
// Assumes an APB word address whose index bits are {bank, bank-relative offset}.
// Function
// [RULE1] An unmasked flag set while asleep is what wakes the device.
// [RULE2] Interrupt wake-up with global disable clear loads the interrupt vector.
// [RULE3] Port data writes hit the output latch; reads return the pin level.
// [RULE4] External memory mode drives ports C, D, E regardless of their registers.
// [RULE5] Unimplemented bits read as zero under every reset class.
// [RULE6] Cold and warm resets set port C and D direction to ones; wake keeps.
// [RULE7] Cold and warm resets set port E direction low nibble; latch is kept.
// [RULE8] Flag register one loads 0000 0010; warm reset keeps bit seven.
// [RULE9] Cold and warm resets clear interrupt enable one; wake keeps it.
// [RULE10] Both timer control registers clear on cold and warm reset, kept on wake.
// [RULE11] Timer, period, capture-one and duty high registers keep values on reset.
// [RULE12] Cold and warm reset clear the low bit of PWM two duty low.
// [RULE13] Each bank decodes offsets 10h to 17h; period three shares with capture one.
`ifndef SFRB_CFG_SVH
`define SFRB_CFG_SVH

// Bank numbers and offset window
`define SFRB_BANK_NONE 2'h0
`define SFRB_BANK_PORT 2'h1
`define SFRB_BANK_TMR  2'h2
`define SFRB_BANK_PWM  2'h3
`define SFRB_OFF_HI    2'h2

// Register indices, bank times 32 plus offset
`define SFRB_IDX_PCDIR {`SFRB_BANK_PORT, 5'h10}
`define SFRB_IDX_PCLAT {`SFRB_BANK_PORT, 5'h11}
`define SFRB_IDX_PDDIR {`SFRB_BANK_PORT, 5'h12}
`define SFRB_IDX_PDLAT {`SFRB_BANK_PORT, 5'h13}
`define SFRB_IDX_PEDIR {`SFRB_BANK_PORT, 5'h14}
`define SFRB_IDX_PELAT {`SFRB_BANK_PORT, 5'h15}
`define SFRB_IDX_IRQF  {`SFRB_BANK_PORT, 5'h16}
`define SFRB_IDX_IRQE  {`SFRB_BANK_PORT, 5'h17}
`define SFRB_IDX_T1    {`SFRB_BANK_TMR, 5'h10}
`define SFRB_IDX_T2    {`SFRB_BANK_TMR, 5'h11}
`define SFRB_IDX_T3L   {`SFRB_BANK_TMR, 5'h12}
`define SFRB_IDX_T3H   {`SFRB_BANK_TMR, 5'h13}
`define SFRB_IDX_P1    {`SFRB_BANK_TMR, 5'h14}
`define SFRB_IDX_P2    {`SFRB_BANK_TMR, 5'h15}
`define SFRB_IDX_P3L   {`SFRB_BANK_TMR, 5'h16}
`define SFRB_IDX_P3H   {`SFRB_BANK_TMR, 5'h17}
`define SFRB_IDX_PW1L  {`SFRB_BANK_PWM, 5'h10}
`define SFRB_IDX_PW2L  {`SFRB_BANK_PWM, 5'h11}
`define SFRB_IDX_PW1H  {`SFRB_BANK_PWM, 5'h12}
`define SFRB_IDX_PW2H  {`SFRB_BANK_PWM, 5'h13}
`define SFRB_IDX_CAPTURE_TWO_LOW  {`SFRB_BANK_PWM, 5'h14}
`define SFRB_IDX_CAPTURE_TWO_HIGH  {`SFRB_BANK_PWM, 5'h15}
`define SFRB_IDX_TC1   {`SFRB_BANK_PWM, 5'h16}
`define SFRB_IDX_TC2   {`SFRB_BANK_PWM, 5'h17}

// Reset values and field masks
`define SFRB_DIR_INIT   8'hFF
`define SFRB_PEDIR_INIT 4'hF
`define SFRB_ZERO8      8'h00
`define SFRB_IRQ1_INIT  8'h02
`define SFRB_IRQ1_KEEP  8'h80
`define SFRB_PW1L_MASK  8'hC0
`define SFRB_PW2L_MASK  8'hE0
`define SFRB_PW2L_LSB   8'h20
`define SFRB_NIB_PAD    4'h0
`define SFRB_DATA_PAD   24'h000000
`define SFRB_VECTOR     16'h0020

`endif

// *** core/sfrb_pkg.sv ***
// Types of the banked register block: reset classes, sleep mode and state records.
// Assumes the constants of sfrb_cfg.svh for widths of the register fields.
package sfrb_pkg;

  typedef enum logic [1:0] {SFRB_RC_NONE, SFRB_RC_COLD, SFRB_RC_WARM, SFRB_RC_WAKE} sfrb_rclass_t;

  typedef enum logic {SFRB_AWAKE, SFRB_ASLEEP} sfrb_mode_t;

  typedef struct packed {
    sfrb_mode_t   mode;
    sfrb_rclass_t rclass;
    logic         vec_load;
  } sfrb_cls_state_t;

  typedef struct packed {
    logic [7:0]  pc_dir, pc_lat, pd_dir, pd_lat;
    logic [3:0]  pe_dir, pe_lat;
    logic [7:0]  irq1, ien1;
    logic [7:0]  t1, t2, t3l, t3h, p1, p2, p3l, p3h;
    logic [7:0]  pw1l, pw2l, pw1h, pw2h, capture_two_low, capture_two_high, tc1, tc2;
    logic        pready, pslverr;
    logic [31:0] prdata;
    logic        irq, vec_load;
    logic [15:0] vec_addr;
    logic [7:0]  pc_out, pc_oe, pd_out, pd_oe;
    logic [3:0]  pe_out, pe_oe;
  } sfrb_state_t;

endpackage

// *** core/sfrb_rst_class.sv ***
// Reset class unit: turns reset unit requests and interrupt wake-up into class pulses.
// Assumes requests are synchronous to clk; cold requests win over warm ones.
`timescale 1ns/1ps
`include "sfrb_cfg.svh"

module sfrb_rst_class
  import sfrb_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Reset unit requests
  input  wire logic por_req,
  input  wire logic bor_req,
  input  wire logic master_clear_reset_req,
  input  wire logic wdt_req,
  input  wire logic sleep_req,
  input  wire logic global_interrupt_disable,
  // Class pulses to the register bank
  sfrb_rst_if.src   rif
);

  sfrb_cls_state_t st;
  sfrb_cls_state_t next_st;

  always_comb begin
    next_st          = st;
    next_st.rclass   = SFRB_RC_NONE;
    next_st.vec_load = 1'b0;
    if (por_req || bor_req) begin
      next_st.rclass = SFRB_RC_COLD;
      next_st.mode   = SFRB_AWAKE;
    end else if (master_clear_reset_req || wdt_req) begin
      next_st.rclass = SFRB_RC_WARM;
      next_st.mode   = SFRB_AWAKE;
    end else begin
      unique case (st.mode)
        SFRB_AWAKE: begin
          if (sleep_req) begin
            next_st.mode = SFRB_ASLEEP;
          end
        end
        SFRB_ASLEEP: begin
          if (rif.irq_pending) begin // see [RULE1]
            next_st.mode     = SFRB_AWAKE;
            next_st.rclass   = SFRB_RC_WAKE;
            next_st.vec_load = ~global_interrupt_disable; // see [RULE2]
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{mode: SFRB_AWAKE, rclass: SFRB_RC_NONE, vec_load: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rif.rclass   = st.rclass;
  assign rif.vec_load = st.vec_load;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_asleep_irq;
    st.mode == SFRB_ASLEEP && rif.irq_pending && !(por_req || bor_req || master_clear_reset_req || wdt_req);
  endsequence

  chk_wake_vector_load: assert property ( // see [RULE2]
    seq_asleep_irq and !global_interrupt_disable |=> rif.vec_load && rif.rclass == SFRB_RC_WAKE ##1 !rif.vec_load)
    else $error("wake-up with interrupts enabled did not load the vector");

  chk_wake_by_flag: assert property ( // see [RULE1]
    rif.rclass == SFRB_RC_WAKE |-> $past(st.mode) == SFRB_ASLEEP && $past(rif.irq_pending))
    else $error("wake-up class without a pending flag while asleep");

endmodule // sfrb_rst_class

// *** core/sfrb_rst_if.sv ***
// Link between the reset class unit and the register bank.
// Assumes one clock domain; all signals are levels registered by their driver.
`timescale 1ns/1ps
interface sfrb_rst_if;
  import sfrb_pkg::*;
  sfrb_rclass_t rclass;
  logic         vec_load;
  logic         irq_pending;
  modport src (output rclass, output vec_load, input irq_pending);
  modport dst (input rclass, input vec_load, output irq_pending);
endinterface

// *** core/sfrb_top.sv ***
// Banked register block, banks one to three, offsets 10h to 17h, behind an APB slave.
// Assumes reset unit requests, peripheral events and pins are synchronous to clk.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "sfrb_cfg.svh"

module sfrb_top
  import sfrb_pkg::*;
#(
  parameter logic [15:0] VECTOR_ADDR = `SFRB_VECTOR
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic [8:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset unit
  input  wire logic        por_req,
  input  wire logic        bor_req,
  input  wire logic        master_clear_reset_req,
  input  wire logic        wdt_req,
  input  wire logic        sleep_req,
  input  wire logic        global_interrupt_disable,
  // Core
  output logic             irq,
  output logic             pc_vector_load,
  output logic      [15:0] pc_vector,
  // Peripheral events and captures
  input  wire logic [7:0]  irq_events,
  input  wire logic        capture_one_mode,
  input  wire logic        capture_one_load,
  input  wire logic [15:0] capture_one_value,
  input  wire logic        capture_two_load,
  input  wire logic [15:0] capture_two_value,
  // Port pins
  input  wire logic [7:0]  port_c_in,
  output logic      [7:0]  port_c_out,
  output logic      [7:0]  port_c_oe,
  input  wire logic [7:0]  port_d_in,
  output logic      [7:0]  port_d_out,
  output logic      [7:0]  port_d_oe,
  input  wire logic [3:0]  port_e_in,
  output logic      [3:0]  port_e_out,
  output logic      [3:0]  port_e_oe,
  // External memory interface
  input  wire logic        ext_mem_mode,
  input  wire logic [7:0]  ext_c_out,
  input  wire logic [7:0]  ext_c_oe,
  input  wire logic [7:0]  ext_d_out,
  input  wire logic [7:0]  ext_d_oe,
  input  wire logic [3:0]  ext_e_out,
  input  wire logic [3:0]  ext_e_oe
);

  sfrb_state_t st;
  sfrb_state_t next_st;
  sfrb_rst_if  rif ();

  logic [6:0] idx;
  logic [1:0] bank;
  logic [4:0] off;
  logic       hit;
  logic       setup;
  logic       wr;
  logic [7:0] wdat;

  // Address decode
  assign idx   = paddr[8:2];
  assign bank  = paddr[8:7];
  assign off   = paddr[6:2];
  assign hit   = (bank != `SFRB_BANK_NONE) && (off[4:3] == `SFRB_OFF_HI); // see [RULE13]
  assign setup = psel && !penable && !st.pready;
  assign wr    = psel && penable && st.pready && pwrite && hit && pstrb[0];
  assign wdat  = pwdata[7:0];

  sfrb_rst_class u_rst_class (
    .clk       (clk),
    .rst_n     (rst_n),
    .por_req   (por_req),
    .bor_req   (bor_req),
    .master_clear_reset_req  (master_clear_reset_req),
    .wdt_req   (wdt_req),
    .sleep_req (sleep_req),
    .global_interrupt_disable    (global_interrupt_disable),
    .rif       (rif.src)
  );

  assign rif.irq_pending = st.irq;

  always_comb begin
    logic [7:0] rd;
    rd               = `SFRB_ZERO8;
    next_st          = st;
    next_st.pready   = 1'b0;
    next_st.pslverr  = 1'b0;
    next_st.vec_load = rif.vec_load; // see [RULE2]
    next_st.vec_addr = VECTOR_ADDR;

    // Read mux, upper bits of narrow registers read as zero
    case (idx) // see [RULE13]
      `SFRB_IDX_PCDIR: rd = st.pc_dir;
      `SFRB_IDX_PCLAT: rd = port_c_in; // see [RULE3]
      `SFRB_IDX_PDDIR: rd = st.pd_dir;
      `SFRB_IDX_PDLAT: rd = port_d_in; // see [RULE3]
      `SFRB_IDX_PEDIR: rd = {`SFRB_NIB_PAD, st.pe_dir}; // see [RULE5]
      `SFRB_IDX_PELAT: rd = {`SFRB_NIB_PAD, port_e_in}; // see [RULE5]
      `SFRB_IDX_IRQF:  rd = st.irq1;
      `SFRB_IDX_IRQE:  rd = st.ien1;
      `SFRB_IDX_T1:    rd = st.t1;
      `SFRB_IDX_T2:    rd = st.t2;
      `SFRB_IDX_T3L:   rd = st.t3l;
      `SFRB_IDX_T3H:   rd = st.t3h;
      `SFRB_IDX_P1:    rd = st.p1;
      `SFRB_IDX_P2:    rd = st.p2;
      `SFRB_IDX_P3L:   rd = st.p3l;
      `SFRB_IDX_P3H:   rd = st.p3h;
      `SFRB_IDX_PW1L:  rd = st.pw1l & `SFRB_PW1L_MASK; // see [RULE5]
      `SFRB_IDX_PW2L:  rd = st.pw2l & `SFRB_PW2L_MASK; // see [RULE5]
      `SFRB_IDX_PW1H:  rd = st.pw1h;
      `SFRB_IDX_PW2H:  rd = st.pw2h;
      `SFRB_IDX_CAPTURE_TWO_LOW:  rd = st.capture_two_low;
      `SFRB_IDX_CAPTURE_TWO_HIGH:  rd = st.capture_two_high;
      `SFRB_IDX_TC1:   rd = st.tc1;
      `SFRB_IDX_TC2:   rd = st.tc2;
      default:         rd = `SFRB_ZERO8;
    endcase

    // Setup phase answers in the following access cycle
    if (setup) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !hit;
      next_st.prdata  = {`SFRB_DATA_PAD, rd};
    end

    // Register writes at the completing access edge
    if (wr) begin
      case (idx) // see [RULE13]
        `SFRB_IDX_PCDIR: next_st.pc_dir = wdat;
        `SFRB_IDX_PCLAT: next_st.pc_lat = wdat;
        `SFRB_IDX_PDDIR: next_st.pd_dir = wdat;
        `SFRB_IDX_PDLAT: next_st.pd_lat = wdat;
        `SFRB_IDX_PEDIR: next_st.pe_dir = wdat[3:0];
        `SFRB_IDX_PELAT: next_st.pe_lat = wdat[3:0];
        `SFRB_IDX_IRQF:  next_st.irq1   = st.irq1 & ~wdat;
        `SFRB_IDX_IRQE:  next_st.ien1   = wdat;
        `SFRB_IDX_T1:    next_st.t1     = wdat;
        `SFRB_IDX_T2:    next_st.t2     = wdat;
        `SFRB_IDX_T3L:   next_st.t3l    = wdat;
        `SFRB_IDX_T3H:   next_st.t3h    = wdat;
        `SFRB_IDX_P1:    next_st.p1     = wdat;
        `SFRB_IDX_P2:    next_st.p2     = wdat;
        `SFRB_IDX_P3L: begin
          if (!capture_one_mode) begin
            next_st.p3l = wdat;
          end
        end
        `SFRB_IDX_P3H: begin
          if (!capture_one_mode) begin
            next_st.p3h = wdat;
          end
        end
        `SFRB_IDX_PW1L:  next_st.pw1l   = wdat & `SFRB_PW1L_MASK;
        `SFRB_IDX_PW2L:  next_st.pw2l   = wdat & `SFRB_PW2L_MASK;
        `SFRB_IDX_PW1H:  next_st.pw1h   = wdat;
        `SFRB_IDX_PW2H:  next_st.pw2h   = wdat;
        `SFRB_IDX_TC1:   next_st.tc1    = wdat;
        `SFRB_IDX_TC2:   next_st.tc2    = wdat;
        default: begin
        end
      endcase
    end

    // Peripheral events set flags; a set wins over a clear
    next_st.irq1 = next_st.irq1 | irq_events; // see [RULE1]

    // Capture loads into the shared and the read-only pairs
    if (capture_one_mode && capture_one_load) begin // see [RULE13]
      next_st.p3l = capture_one_value[7:0];
      next_st.p3h = capture_one_value[15:8];
    end
    if (capture_two_load) begin
      next_st.capture_two_low = capture_two_value[7:0];
      next_st.capture_two_high = capture_two_value[15:8];
    end

    // Reset classes; timers, periods, duty high and latches are left as they are
    unique case (rif.rclass) // see [RULE11]
      SFRB_RC_COLD, SFRB_RC_WARM: begin
        next_st.pc_dir = `SFRB_DIR_INIT; // see [RULE6]
        next_st.pd_dir = `SFRB_DIR_INIT; // see [RULE6]
        next_st.pe_dir = `SFRB_PEDIR_INIT; // see [RULE7]
        next_st.ien1   = `SFRB_ZERO8; // see [RULE9]
        next_st.tc1    = `SFRB_ZERO8; // see [RULE10]
        next_st.tc2    = `SFRB_ZERO8; // see [RULE10]
        next_st.pw2l   = st.pw2l & ~`SFRB_PW2L_LSB; // see [RULE12]
        if (rif.rclass == SFRB_RC_WARM) begin
          next_st.irq1 = (st.irq1 & `SFRB_IRQ1_KEEP) | `SFRB_IRQ1_INIT; // see [RULE8]
        end else begin
          next_st.irq1 = `SFRB_IRQ1_INIT; // see [RULE8]
        end
      end
      SFRB_RC_WAKE, SFRB_RC_NONE: begin
      end
    endcase

    // Pin drive, handed to the external memory interface when selected
    if (ext_mem_mode) begin // see [RULE4]
      next_st.pc_out = ext_c_out;
      next_st.pc_oe  = ext_c_oe;
      next_st.pd_out = ext_d_out;
      next_st.pd_oe  = ext_d_oe;
      next_st.pe_out = ext_e_out;
      next_st.pe_oe  = ext_e_oe;
    end else begin
      next_st.pc_out = next_st.pc_lat; // see [RULE3]
      next_st.pc_oe  = ~next_st.pc_dir;
      next_st.pd_out = next_st.pd_lat;
      next_st.pd_oe  = ~next_st.pd_dir;
      next_st.pe_out = next_st.pe_lat;
      next_st.pe_oe  = ~next_st.pe_dir;
    end

    // Level interrupt from unmasked flags
    next_st.irq = |(next_st.irq1 & next_st.ien1);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= '0;
      st.pc_dir <= `SFRB_DIR_INIT;
      st.pd_dir <= `SFRB_DIR_INIT;
      st.pe_dir <= `SFRB_PEDIR_INIT;
      st.irq1   <= `SFRB_IRQ1_INIT;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state
  assign prdata         = st.prdata;
  assign pready         = st.pready;
  assign pslverr        = st.pslverr;
  assign irq            = st.irq;
  assign pc_vector_load = st.vec_load;
  assign pc_vector      = st.vec_addr;
  assign port_c_out     = st.pc_out;
  assign port_c_oe      = st.pc_oe;
  assign port_d_out     = st.pd_out;
  assign port_d_oe      = st.pd_oe;
  assign port_e_out     = st.pe_out;
  assign port_e_oe      = st.pe_oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_reset_class;
    rif.rclass == SFRB_RC_COLD || rif.rclass == SFRB_RC_WARM;
  endsequence

  sequence seq_read_setup(logic [6:0] where);
    setup && !pwrite && idx == where;
  endsequence

  chk_dir_ones_reset: assert property ( // see [RULE6]
    seq_reset_class |=> st.pc_dir == `SFRB_DIR_INIT && st.pd_dir == `SFRB_DIR_INIT
                        && st.pe_dir == `SFRB_PEDIR_INIT)
    else $error("direction registers not all ones after reset class");

  chk_wake_keeps_dir: assert property ( // see [RULE6]
    rif.rclass == SFRB_RC_WAKE && !wr |=> $stable(st.pc_dir) && $stable(st.pd_dir)
                                         && $stable(st.pe_dir) && $stable(st.pe_lat))
    else $error("wake-up changed direction or port E latch");

  chk_flags_warm_keep: assert property ( // see [RULE8]
    rif.rclass == SFRB_RC_WARM |=>
      st.irq1 == (($past(st.irq1) & `SFRB_IRQ1_KEEP) | `SFRB_IRQ1_INIT))
    else $error("flag register one wrong after warm reset");

  chk_enable_clear: assert property ( // see [RULE9]
    seq_reset_class |=> st.ien1 == `SFRB_ZERO8 && !irq)
    else $error("interrupt enable one not cleared by reset class");

  chk_tcon_clear: assert property ( // see [RULE10]
    seq_reset_class |=> st.tc1 == `SFRB_ZERO8 && st.tc2 == `SFRB_ZERO8)
    else $error("timer control not cleared by reset class");

  chk_timers_kept: assert property ( // see [RULE11]
    seq_reset_class and !wr and !capture_one_load |=>
      $stable(st.t1) && $stable(st.p1) && $stable(st.p3l) && $stable(st.pw1h))
    else $error("timer or duty value changed by reset class");

  chk_pw2_lsb_clear: assert property ( // see [RULE12]
    seq_reset_class |=> (st.pw2l & `SFRB_PW2L_LSB) == `SFRB_ZERO8
                        && (st.pw2l & ~`SFRB_PW2L_LSB) == ($past(st.pw2l) & ~`SFRB_PW2L_LSB))
    else $error("PWM two duty low bit not cleared or duty bits lost");

  chk_pin_read: assert property ( // see [RULE3]
    seq_read_setup(`SFRB_IDX_PCLAT) |=> pready && prdata[7:0] == $past(port_c_in))
    else $error("port C read did not return pin level");

  chk_unimpl_zero: assert property ( // see [RULE5]
    seq_read_setup(`SFRB_IDX_PEDIR) |=> pready && prdata[31:4] == 28'h0000000)
    else $error("unimplemented port E direction bits read nonzero");

  chk_extmem_pins: assert property ( // see [RULE4]
    ext_mem_mode |=> port_c_oe == $past(ext_c_oe) && port_d_out == $past(ext_d_out)
                     && port_e_oe == $past(ext_e_oe))
    else $error("external memory mode did not own the port pins");

  chk_flag_set_wins: assert property ( // see [RULE1]
    rif.rclass == SFRB_RC_NONE |=> (st.irq1 & $past(irq_events)) == $past(irq_events))
    else $error("peripheral event lost against a flag clear");

  chk_shared_decode: assert property ( // see [RULE13]
    wr && idx == `SFRB_IDX_P3H && !capture_one_mode && !capture_one_load
       && rif.rclass == SFRB_RC_NONE |=> st.p3h == $past(wdat) && !pready)
    else $error("period three high write did not land at its offset");

endmodule // sfrb_top

// *** test/sfrb_top_bench.sv ***
// Self-checking bench for the banked register block, driven over APB.
// Assumes sfrb_top raises pready in the cycle after each setup cycle, with no wait states.
`timescale 1ns/1ps
`include "sfrb_cfg.svh"

module sfrb_top_bench;
  import sfrb_pkg::*;

  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        por_req, bor_req, master_clear_reset_req, wdt_req, sleep_req, global_interrupt_disable;
  logic        irq, pc_vector_load, capture_two_load, ext_mem_mode, capture_one_mode;
  logic [8:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, port_e_in, port_e_out, port_e_oe, ext_e_out, ext_e_oe;
  logic [15:0] pc_vector, capture_two_value;
  logic [7:0]  irq_events, port_c_in, port_c_out, port_c_oe, port_d_in;
  logic [7:0]  port_d_out, port_d_oe, ext_c_out, ext_c_oe, ext_d_out, ext_d_oe;
  logic [7:0]  rnd, lat, pin;
  logic [9:0]  exp_q[$];
  logic [9:0]  e;
  logic [7:0]  v [10];
  int          errors, check_count, cyc, n;

  // Storage registers: index, writable bits, bits kept and bits set by a reset class
  localparam logic [6:0] IDX [10] = '{`SFRB_IDX_PCDIR, `SFRB_IDX_PDDIR, `SFRB_IDX_PEDIR,
    `SFRB_IDX_IRQE, `SFRB_IDX_T1, `SFRB_IDX_P1, `SFRB_IDX_P3H, `SFRB_IDX_PW1L,
    `SFRB_IDX_PW2L, `SFRB_IDX_TC1};
  localparam logic [7:0] MSK [10] = '{8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hC0, 8'hE0, 8'hFF};
  localparam logic [7:0] KEEP [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF,
    8'hC0, 8'hC0, 8'h00};
  localparam logic [7:0] SETV [10] = '{8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};

  sfrb_top dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .por_req, .bor_req, .master_clear_reset_req, .wdt_req, .sleep_req, .global_interrupt_disable, .irq,
    .pc_vector_load, .pc_vector, .irq_events, .capture_one_mode,
    .capture_one_load(capture_two_load), .capture_one_value(capture_two_value),
    .capture_two_load,
    .capture_two_value, .port_c_in, .port_c_out, .port_c_oe, .port_d_in, .port_d_out,
    .port_d_oe, .port_e_in, .port_e_out, .port_e_oe, .ext_mem_mode, .ext_c_out, .ext_c_oe,
    .ext_d_out, .ext_d_oe, .ext_e_out, .ext_e_oe);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic report_and_stop();
    $display("errors=%0d check_count=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] x, input string m);
    check_count++;
    if (g !== x) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, x);
    end
  endtask

  // One APB transfer; the expected answer is queued for the watcher
  task automatic apb(input logic [6:0] a, input logic w, input logic [7:0] d,
                     input logic [7:0] x, input logic er);
    exp_q.push_back({~w, er, x});
    paddr   <= {a, 2'b00};
    pwrite  <= w;
    pwdata  <= {24'h000000, d};
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    apb(a, 1'b1, d, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] x);
    apb(a, 1'b0, 8'h00, x, 1'b0);
  endtask

  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp(1, 0, "answer without request");
      end else begin
        e = exp_q.pop_front();
        cmp(pslverr, e[8], "error flag");
        if (e[9]) cmp(prdata, {24'h000000, e[7:0]}, "read data");
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 9'h000;
    pwdata = 32'h0; pstrb = 4'hF; por_req = 1'b0; bor_req = 1'b0; master_clear_reset_req = 1'b0;
    wdt_req = 1'b0; sleep_req = 1'b0; global_interrupt_disable = 1'b0; irq_events = 8'h00;
    capture_two_load = 1'b0; capture_two_value = 16'h0; ext_mem_mode = 1'b0;
    port_c_in = 8'h00; port_d_in = 8'h00; port_e_in = 4'h0; ext_c_out = 8'h00;
    ext_c_oe = 8'h00; ext_d_out = 8'h00; ext_d_oe = 8'h00; rnd = 8'h0E;
    ext_e_out = 4'h0; ext_e_oe = 4'h0; capture_one_mode = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 10; i++) rd(IDX[i], SETV[i]);
    rd(`SFRB_IDX_IRQF, 8'h02);
    apb({2'h0, 5'h10}, 1'b0, 8'h00, 8'h00, 1'b1);
    apb({2'h1, 5'h08}, 1'b1, 8'hFF, 8'h00, 1'b1);
    pstrb <= 4'h0;
    wr(`SFRB_IDX_TC2, 8'h55);
    pstrb <= 4'hF;
    rd(`SFRB_IDX_TC2, 8'h00);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 10; i++) begin
        rnd = lfsr(rnd);
        v[i] = rnd & MSK[i];
        wr(IDX[i], rnd);
        rd(IDX[i], v[i]);
      end
      lat = lfsr(rnd);
      pin = ~lat;
      port_c_in <= pin;
      wr(`SFRB_IDX_PCLAT, lat);
      irq_events <= 8'h81;
      @(posedge clk);
      irq_events <= 8'h00;
      master_clear_reset_req <= (k == 0);
      wdt_req  <= (k == 1);
      por_req  <= (k == 2);
      bor_req  <= (k == 3);
      @(posedge clk);
      {master_clear_reset_req, wdt_req, por_req, bor_req} <= 4'h0;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
        rd(IDX[i], (v[i] & KEEP[i]) | SETV[i]);
      end
      rd(`SFRB_IDX_IRQF, (k < 2) ? 8'h82 : 8'h02);
      rd(`SFRB_IDX_PCLAT, pin);
      cmp(port_c_out, lat, "latch on pins");
      cmp(port_c_oe, 8'h00, "port c drive");
      cmp({port_d_oe, port_e_oe}, 12'h000, "port d and e drive");
    end
    ext_c_out <= rnd;
    ext_c_oe  <= ~rnd;
    ext_d_out <= ~rnd;
    ext_d_oe  <= rnd;
    ext_e_out <= rnd[3:0];
    ext_e_oe  <= rnd[7:4];
    ext_mem_mode <= 1'b1;
    repeat (3) @(posedge clk);
    cmp({port_c_out, port_c_oe}, {rnd, ~rnd}, "external drive");
    cmp({port_d_out, port_d_oe}, {~rnd, rnd}, "external drive d");
    cmp({port_e_out, port_e_oe}, {rnd[3:0], rnd[7:4]}, "external drive e");
    ext_mem_mode <= 1'b0;
    capture_one_mode <= 1'b1;
    capture_two_value <= 16'hA5C3;
    capture_two_load <= 1'b1;
    @(posedge clk);
    capture_two_load <= 1'b0;
    wr(`SFRB_IDX_CAPTURE_TWO_LOW, 8'h11);
    wr(`SFRB_IDX_P3L, 8'h11);
    rd(`SFRB_IDX_CAPTURE_TWO_LOW, 8'hC3);
    rd(`SFRB_IDX_CAPTURE_TWO_HIGH, 8'hA5);
    rd(`SFRB_IDX_P3L, 8'hC3);
    rd(`SFRB_IDX_P3H, 8'hA5);
    capture_one_mode <= 1'b0;
    wr(`SFRB_IDX_IRQE, 8'h01);
    irq_events <= 8'h01;
    @(posedge clk);
    irq_events <= 8'h00;
    repeat (2) @(posedge clk);
    cmp(irq, 1'b1, "unmasked flag");
    wr(`SFRB_IDX_IRQE, 8'h00);
    cmp(irq, 1'b0, "masked flag");
    wr(`SFRB_IDX_IRQF, 8'h03);
    rd(`SFRB_IDX_IRQF, 8'h00);
    wr(`SFRB_IDX_IRQE, 8'h01);
    wr(`SFRB_IDX_PCDIR, 8'h00);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge clk);
    irq_events <= 8'h01;
    @(posedge clk);
    irq_events <= 8'h00;
    n = 0;
    while (pc_vector_load !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    cmp({pc_vector_load, pc_vector}, {1'b1, `SFRB_VECTOR}, "wake vector");
    rd(`SFRB_IDX_PCDIR, 8'h00);
    rd(`SFRB_IDX_IRQE, 8'h01);
    rd(`SFRB_IDX_IRQF, 8'h01);
    global_interrupt_disable <= 1'b1;
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    n = 0;
    repeat (6) begin
      @(posedge clk);
      if (pc_vector_load !== 1'b0) n++;
    end
    cmp(n, 0, "vector load while disabled");
    rd(`SFRB_IDX_PCDIR, 8'h00);
    repeat (2) @(posedge clk);
    report_and_stop();
  end

endmodule // sfrb_top_bench
